// ### rtl/psc_host.sv
// host controller driving the pseudo sram asynchronous port
//
// Function
// - power down entered only from standby, chip select already high.
// - selected but idle state never held longer than 1 us.
// - at least one lane select held low during a read.
// - lane selects made valid before any read or write begins.
// - successive read cycles spaced no closer than read_cycle_time.
// - chip select to output strobe delay between minimum and 1000 ns.
// - address setup to chip select only counts if strobe fell first.
// - power_enable and write strobe stay high for the whole read.
`timescale 1ns/100ps

module psc_host #(
  parameter int ADDR_W = psc_pkg::ADDR_W,
  parameter int DATA_W = psc_pkg::DATA_W
) (
  input  wire logic              CORE_CLK,
  input  wire logic              RST,
  input  wire logic              REQ_VALID,
  input  wire logic              REQ_WRITE,
  input  wire logic [ADDR_W-1:0] REQ_ADDR,
  input  wire logic [DATA_W-1:0] REQ_WDATA,
  input  wire logic [1:0]        REQ_LANE_N,
  input  wire logic              PDOWN_REQ,
  output logic                   REQ_READY,
  output logic                   RD_VALID,
  output logic [DATA_W-1:0]      RD_DATA,
  output logic                   CHIP_SELECT_N,
  output logic                   POWER_ENABLE,
  output logic                   WRITE_N,
  output logic                   OUTPUT_N,
  output logic                   LOW_LANE_SELECT_N,
  output logic                   HIGH_LANE_SELECT_N,
  output logic [ADDR_W-1:0]      WORD_ADDRESS,
  output logic [DATA_W-1:0]      DQ_OUT,
  output logic                   DQ_OE,
  input  wire logic [DATA_W-1:0] DQ_IN
);
  typedef logic [psc_pkg::CNT_W-1:0] psc_cnt_t;

  // read data passes two flops, so the strobe stays low that much longer
  localparam int SYNC_STAGES = 2;
  localparam int OE_NEED_I   = psc_pkg::OE_ACC_CYC + SYNC_STAGES;
  localparam int RC_LEFT_I   = psc_pkg::RC_CYC - psc_pkg::CLOL_CYC;
  localparam int OE_HOLD_I   = (OE_NEED_I > RC_LEFT_I) ? OE_NEED_I
                                                       : RC_LEFT_I;

  localparam psc_cnt_t SETUP_C   = psc_cnt_t'(psc_pkg::SETUP_CYC);
  localparam psc_cnt_t CLOL_C    = psc_cnt_t'(psc_pkg::CLOL_CYC);
  localparam psc_cnt_t OE_HOLD_C = psc_cnt_t'(OE_HOLD_I);
  localparam psc_cnt_t WR_C      = psc_cnt_t'(psc_pkg::WR_CYC);
  localparam psc_cnt_t CHZ_C     = psc_cnt_t'(psc_pkg::CHZ_CYC);
  localparam psc_cnt_t ONE_C     = psc_cnt_t'(1);

  // elaboration checks
  if (ADDR_W != 19 || DATA_W != 16) begin : g_bad_size
    $error("psc_host: only 512K words of 16 bits are served");
  end
  if (OE_HOLD_I >= 2 ** psc_pkg::CNT_W) begin : g_bad_cnt
    $error("psc_host: counter too narrow for the read strobe");
  end
  if (psc_pkg::WR_CYC >= 2 ** psc_pkg::CNT_W) begin : g_bad_wr
    $error("psc_host: counter too narrow for the write strobe");
  end
  if (psc_pkg::CLOL_CYC > psc_pkg::CLOL_MAX_CYC) begin : g_bad_clol
    $error("psc_host: select to strobe delay beyond its limit");
  end
  if (psc_pkg::CLOL_CYC >= psc_pkg::OD_MAX_CYC) begin : g_bad_od
    $error("psc_host: selected idle time beyond its limit");
  end
  if (psc_pkg::SETUP_CYC < 1 || psc_pkg::CHZ_CYC < 1) begin : g_bad_gap
    $error("psc_host: setup and recovery need one cycle at least");
  end

  psc_pkg::psc_state_t state_ff;
  psc_cnt_t            cnt_ff;
  logic                ready_ff;
  logic                rd_valid_ff;
  logic [DATA_W-1:0]   rd_data_ff;
  logic                cs_n_ff;
  logic                pe_ff;
  logic                we_n_ff;
  logic                oe_n_ff;
  logic                lo_n_ff;
  logic                hi_n_ff;
  logic [ADDR_W-1:0]   addr_ff;
  logic [DATA_W-1:0]   dq_out_ff;
  logic                dq_oe_ff;
  logic                wr_ff;
  logic [DATA_W-1:0]   dq_meta_ff;
  logic [DATA_W-1:0]   dq_sync_ff;
  logic                accept;
  logic                pd_entry;
  logic                pd_exit;
  logic                setup_end;
  logic                ce_end;
  logic                oe_end;
  logic                wr_end;
  logic                recov_end;
  logic                leave;

  // a request wins over power down in the same cycle
  assign accept    = REQ_VALID && ready_ff;
  assign pd_entry  = (state_ff == psc_pkg::PSC_IDLE) && !accept
                     && PDOWN_REQ;
  assign pd_exit   = (state_ff == psc_pkg::PSC_PDOWN) && !PDOWN_REQ;
  assign setup_end = (state_ff == psc_pkg::PSC_SETUP)
                     && (cnt_ff == SETUP_C - ONE_C);
  assign ce_end    = (state_ff == psc_pkg::PSC_RD_CE)
                     && (cnt_ff == CLOL_C - ONE_C);
  assign oe_end    = (state_ff == psc_pkg::PSC_RD_OE)
                     && (cnt_ff == OE_HOLD_C - ONE_C);
  assign wr_end    = (state_ff == psc_pkg::PSC_WR)
                     && (cnt_ff == WR_C - ONE_C);
  assign recov_end = (state_ff == psc_pkg::PSC_RECOV)
                     && (cnt_ff == CHZ_C - ONE_C);
  assign leave     = accept || pd_entry || pd_exit || setup_end
                     || ce_end || oe_end || wr_end || recov_end;

  // sequencer
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state_ff <= psc_pkg::PSC_IDLE;
    end else begin
      case (state_ff)
        psc_pkg::PSC_IDLE: begin
          if (accept) begin
            state_ff <= psc_pkg::PSC_SETUP;
          end else if (pd_entry) begin
            state_ff <= psc_pkg::PSC_PDOWN;
          end
        end
        psc_pkg::PSC_SETUP: begin
          if (setup_end) begin
            state_ff <= wr_ff ? psc_pkg::PSC_WR : psc_pkg::PSC_RD_CE;
          end
        end
        psc_pkg::PSC_RD_CE: begin
          if (ce_end) begin
            state_ff <= psc_pkg::PSC_RD_OE;
          end
        end
        psc_pkg::PSC_RD_OE: begin
          if (oe_end) begin
            state_ff <= psc_pkg::PSC_RECOV;
          end
        end
        psc_pkg::PSC_WR: begin
          if (wr_end) begin
            state_ff <= psc_pkg::PSC_RECOV;
          end
        end
        psc_pkg::PSC_RECOV: begin
          if (recov_end) begin
            state_ff <= psc_pkg::PSC_IDLE;
          end
        end
        psc_pkg::PSC_PDOWN: begin
          // recovery also covers select setup after wake up
          if (pd_exit) begin
            state_ff <= psc_pkg::PSC_RECOV;
          end
        end
        default: begin
          state_ff <= psc_pkg::PSC_IDLE;
        end
      endcase
    end
  end

  // cycles spent in the current state
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cnt_ff <= '0;
    end else if (leave) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + ONE_C;
    end
  end

  // request handshake
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ready_ff <= 1'h0;
    end else if (accept || pd_entry) begin
      ready_ff <= 1'h0;
    end else if (recov_end) begin
      ready_ff <= 1'h1;
    end else if (state_ff == psc_pkg::PSC_IDLE && !PDOWN_REQ) begin
      ready_ff <= 1'h1;
    end
  end

  // request latch, held until the next request
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      wr_ff     <= 1'h0;
      addr_ff   <= '0;
      dq_out_ff <= '0;
    end else if (accept) begin
      wr_ff     <= REQ_WRITE;
      addr_ff   <= REQ_ADDR;
      dq_out_ff <= REQ_WDATA;
    end
  end

  // lane selects settle before chip select falls
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      lo_n_ff <= 1'h1;
      hi_n_ff <= 1'h1;
    end else if (accept && REQ_WRITE) begin
      lo_n_ff <= REQ_LANE_N[0];
      hi_n_ff <= REQ_LANE_N[1];
    end else if (accept) begin
      // reads are never masked, so both lanes go low
      lo_n_ff <= 1'h0;
      hi_n_ff <= 1'h0;
    end
  end

  // chip select
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cs_n_ff <= 1'h1;
    end else if (setup_end) begin
      cs_n_ff <= 1'h0;
    end else if (oe_end || wr_end) begin
      cs_n_ff <= 1'h1;
    end
  end

  // power enable, only dropped while deselected
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      pe_ff <= 1'h1;
    end else if (pd_entry) begin
      pe_ff <= 1'h0;
    end else if (pd_exit) begin
      pe_ff <= 1'h1;
    end
  end

  // write strobe and data drive
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      we_n_ff  <= 1'h1;
      dq_oe_ff <= 1'h0;
    end else if (setup_end && wr_ff) begin
      we_n_ff  <= 1'h0;
      dq_oe_ff <= 1'h1;
    end else if (wr_end) begin
      we_n_ff  <= 1'h1;
      dq_oe_ff <= 1'h0;
    end
  end

  // output strobe falls only after chip select
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      oe_n_ff <= 1'h1;
    end else if (ce_end) begin
      oe_n_ff <= 1'h0;
    end else if (oe_end) begin
      oe_n_ff <= 1'h1;
    end
  end

  // data pins come from outside, two flops first
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      dq_meta_ff <= '0;
      dq_sync_ff <= '0;
    end else begin
      dq_meta_ff <= DQ_IN;
      dq_sync_ff <= dq_meta_ff;
    end
  end

  // read result, taken while address and strobes still stand
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rd_valid_ff <= 1'h0;
      rd_data_ff  <= '0;
    end else begin
      rd_valid_ff <= oe_end;
      if (oe_end) begin
        rd_data_ff <= dq_sync_ff;
      end
    end
  end

  assign REQ_READY          = ready_ff;
  assign RD_VALID           = rd_valid_ff;
  assign RD_DATA            = rd_data_ff;
  assign CHIP_SELECT_N      = cs_n_ff;
  assign POWER_ENABLE       = pe_ff;
  assign WRITE_N            = we_n_ff;
  assign OUTPUT_N           = oe_n_ff;
  assign LOW_LANE_SELECT_N  = lo_n_ff;
  assign HIGH_LANE_SELECT_N = hi_n_ff;
  assign WORD_ADDRESS       = addr_ff;
  assign DQ_OUT             = dq_out_ff;
  assign DQ_OE              = dq_oe_ff;
endmodule // psc_host

// ### rtl/psc_pkg.sv
// constants and types for the pseudo sram host port controller
package psc_pkg;
  localparam int ADDR_W    = 19;
  localparam int DATA_W    = 16;
  localparam int CLK_PS    = 5000;
  // read grade limits in ns, faster grade defaults
  localparam int RC_NS     = 70;
  localparam int CE_ACC_NS = 65;
  localparam int OE_ACC_NS = 40;
  localparam int CHZ_NS    = 20;
  localparam int CLOL_NS   = 25;
  localparam int CLOL_MAX_NS = 1000;
  localparam int OD_MAX_NS = 1000;
  localparam int SETUP_NS  = 10;
  // least times round up, longest round down
  localparam int RC_CYC    = (RC_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CLOL_CYC  = (CLOL_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int OE_ACC_CYC = (OE_ACC_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CE_ACC_CYC = (CE_ACC_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CHZ_CYC   = (CHZ_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int SETUP_CYC = (SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int OD_MAX_CYC = (OD_MAX_NS * 1000) / CLK_PS;
  localparam int CLOL_MAX_CYC = (CLOL_MAX_NS * 1000) / CLK_PS;
  localparam int WR_CYC    = RC_CYC;
  localparam int CNT_W     = 8;
  typedef enum logic [2:0] {
    PSC_IDLE, PSC_SETUP, PSC_RD_CE, PSC_RD_OE, PSC_WR, PSC_RECOV, PSC_PDOWN
  } psc_state_t;
endpackage

// ### verification/psc_chk_props.sv
// pin checker for the host port
`timescale 1ns/100ps
module psc_chk (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CHIP_SELECT_N,
  input wire logic WRITE_N,
  input wire logic OUTPUT_N,
  input wire logic POWER_ENABLE,
  input wire logic LOW_LANE_SELECT_N,
  input wire logic HIGH_LANE_SELECT_N
);
  wire c = !CHIP_SELECT_N, o = !OUTPUT_N, w = !WRITE_N, p = POWER_ENABLE;
  wire r = c && o;
  wire [1:0] b = {HIGH_LANE_SELECT_N, LOW_LANE_SELECT_N};
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  a_rd_lane: assert property (r |-> b != 2'h3) else $error("lane");
  a_lane_set: assert property (r |-> $stable(b)) else $error("bv");
  a_rd_pins: assert property (r |-> !w && p) else $error("rd");
  a_wr_pins: assert property (c && w |-> p && !o) else $error("wr");
  a_pd_stby: assert property ($fell(p) |-> !$past(c)) else $error("pd");
  a_oe_gap: assert property ($rose(o) |-> $past(c, 5)) else $error("oe");
  a_rc_min: assert property ($rose(c) |=> c [*8]) else $error("rc");
  a_od_max: assert property ($rose(c) |-> ##[1:200] (!c|o|w))
    else $error("od");
endmodule // psc_chk
bind psc_host psc_chk u_chk (.CORE_CLK, .RST, .CHIP_SELECT_N, .WRITE_N,
  .OUTPUT_N, .POWER_ENABLE, .LOW_LANE_SELECT_N, .HIGH_LANE_SELECT_N);

// ### verification/psc_mem.sv
// behavioural model of the memory device
`timescale 1ns/100ps
module psc_mem (
  input  wire logic        k,
  input  wire logic        c,
  input  wire logic        p,
  input  wire logic        w,
  input  wire logic        o,
  input  wire logic [1:0]  b,
  input  wire logic [18:0] a,
  input  wire logic [15:0] d,
  output logic      [15:0] q
);
  logic [15:0] m [0:19'h7_FFFF];
  // released bus shows the inverse so a stale sample never matches
  assign q = p && !c && !o && w ? m[a] : ~d;
  always @(posedge k) if (p && !c && !w) m[a] <=
    {b[1] ? m[a][15:8] : d[15:8], b[0] ? m[a][7:0] : d[7:0]};
endmodule // psc_mem

// ### verification/tb_top.sv
// bench for the host port
`timescale 1ns/100ps
module tb_top;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        vld = 1'h0;
  logic        wr  = 1'h0;
  logic        pd  = 1'h0;
  logic        rdy;
  logic        rv;
  logic        cs;
  logic        pe;
  logic        we;
  logic        oe;
  logic        oen;
  logic        lo;
  logic        hi;
  logic [1:0]  ln  = 2'h0;
  logic [18:0] ad  = 19'h0_0000;
  logic [18:0] wa;
  logic [15:0] wd  = 16'h0000;
  logic [15:0] e   = 16'h0000;
  logic [15:0] rd;
  logic [15:0] dq;
  logic [15:0] di;
  // rows: write, address, write data, expected read data, lanes
  logic [53:0] t [6] = '{{1'b1, 19'h0_0012, 16'hBEEF, 16'h0000, 2'h0},
    {1'b1, 19'h0_0012, 16'h1234, 16'h0000, 2'h2},
    {1'b1, 19'h7_FFFF, 16'hCAFE, 16'h0000, 2'h0},
    {1'b1, 19'h7_FFFF, 16'h0000, 16'h0000, 2'h1},
    {1'b0, 19'h0_0012, 16'h0000, 16'hBE34, 2'h0},
    {1'b0, 19'h7_FFFF, 16'h0000, 16'h00FE, 2'h0}};
  int num_errors = 0, checks = 0, n;
  always #2.5 clk = !clk;
  psc_host u_dut (.CORE_CLK(clk), .RST(rst), .REQ_VALID(vld), .REQ_WRITE(wr),
    .REQ_ADDR(ad), .REQ_WDATA(wd), .REQ_LANE_N(ln), .PDOWN_REQ(pd),
    .REQ_READY(rdy), .RD_VALID(rv), .RD_DATA(rd), .CHIP_SELECT_N(cs),
    .POWER_ENABLE(pe), .WRITE_N(we), .OUTPUT_N(oe), .LOW_LANE_SELECT_N(lo),
    .HIGH_LANE_SELECT_N(hi), .WORD_ADDRESS(wa), .DQ_OUT(dq), .DQ_OE(oen),
    .DQ_IN(di));
  psc_mem u_mem (.k(clk), .c(cs), .p(pe), .w(we), .o(oe), .b({hi, lo}),
    .a(wa), .d(dq), .q(di));
  task results;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    checks++;
    if (got !== ex) begin
      $display("CHECK FAILED %s exp %h got %h", nm, ex, got);
      num_errors++;
    end
  endtask
  // bounded wait for ready (sel 0) or read valid (sel 1) at a rising edge
  task wait_for(input logic sel);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((sel ? rv : rdy) !== 1'h1 && n < 400);
    if ((sel ? rv : rdy) !== 1'h1) begin
      chk("handshake_timeout", 16'h0001, 16'h0000);
      results;
    end
  endtask
  // request held until ready is seen high at a rising edge
  task access(input logic [53:0] row);
    wait_for(1'h0);
    #1;
    {wr, ad, wd, e, ln} = row;
    vld = 1'h1;
    wait_for(1'h0);
    #1;
    vld = 1'h0;
    if (wr) begin
      wait_for(1'h0);
      chk("write_strobe", 16'h0001, {15'h0000, we});
      chk("data_drive", 16'h0000, {15'h0000, oen});
    end else begin
      wait_for(1'h1);
      chk("read_data", e, rd);
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    chk("reset_ready", 16'h0000, {15'h0000, rdy});
    chk("reset_power", 16'h0001, {15'h0000, pe});
    #1;
    rst = 1'h0;
    foreach (t[i]) begin
      access(t[i]);
      $display("access %0d done", i);
    end
    #1;
    rst = 1'h1;
    @(posedge clk);
    chk("mid_reset_ready", 16'h0000, {15'h0000, rdy});
    chk("mid_reset_select", 16'h0001, {15'h0000, cs});
    #1;
    rst = 1'h0;
    access(t[4]);
    $display("reset test done");
    wait_for(1'h0);
    #1;
    pd = 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pe !== 1'h0 && n < 400);
    chk("pdown_power", 16'h0000, {15'h0000, pe});
    chk("pdown_select", 16'h0001, {15'h0000, cs});
    #1;
    pd = 1'h0;
    access(t[5]);
    $display("power down done");
    results;
  end
endmodule // tb_top
